// *** gpio_port_block.sv ***
// What this block does
// (RQ1) A standard pin is a floating input, pull-up input, open-drain output or push-pull output by direction/option.
// (RQ2) An interrupt pin turns direction 0 option 1 into an interrupt input, pulled up or floating by pin.
// (RQ3) True open-drain pins ignore the option bit: input floats, output is a sink-only drive.
// (RQ4) Software leaves a pin in floating input while it serves as an analog converter input.
// (RQ5) Software changes pin modes only along safe sequences to avoid spurious interrupts.
// (RQ6) In idle mode the ports keep working and a pin interrupt wakes the core.
// (RQ7) In stop mode configuration and outputs hold, and a pin interrupt wakes the core.
// (RQ8) A pin event interrupts only if the pin is set as interrupt input and the global mask is clear.
// (RQ9) The pin interrupt has no readable flag and is enabled only by direction and option bits; the code also gates each vector by vec_en_reg.
// (RQ10) Each pin's drive follows its direction and option bits and its fixed features.
// (RQ11) In input mode a data read returns the pin and a data write only loads the latch.
// (RQ12) In output mode the latch drives the pin and a data read returns the latch.
// (RQ13) Pins on one vector are detected per the sensitivity field, ORed, and cleared by the vector fetch.
// (RQ14) In open-drain output a latch 1 leaves the pin undriven and a 0 pulls it low.
// (RQ15) Each port holds data, direction and option at three consecutive addresses, all cleared by reset.
module gpio_port_block (
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  wire gpio_pkg::bus_req_t    bus_i,
    output logic [7:0]                 rdata_o,
    input  wire gpio_pkg::pin_vec_t    pin_i,
    input  wire gpio_pkg::pin_vec_t    analog_sel_i,
    output gpio_pkg::pin_drive_t       drive_o,
    input  wire logic                  int_mask_i,
    input  wire logic [3:0]            vec_fetch_i,
    output logic [3:0]                 irq_vec_o,
    output logic                       irq_o,
    output logic                       wake_o
);

    // ------------------------------------------------------------------
    // Address tables
    // ------------------------------------------------------------------
    localparam gpio_pkg::addr_t DATA_OFS [gpio_pkg::NUM_PORTS] = '{
        gpio_pkg::PORT_A_DATA_OFS, gpio_pkg::PORT_B_DATA_OFS, gpio_pkg::PORT_C_DATA_OFS,
        gpio_pkg::PORT_D_DATA_OFS, gpio_pkg::PORT_E_DATA_OFS, gpio_pkg::PORT_F_DATA_OFS};
    localparam gpio_pkg::addr_t DIR_OFS [gpio_pkg::NUM_PORTS] = '{
        gpio_pkg::PORT_A_DIR_OFS, gpio_pkg::PORT_B_DIR_OFS, gpio_pkg::PORT_C_DIR_OFS,
        gpio_pkg::PORT_D_DIR_OFS, gpio_pkg::PORT_E_DIR_OFS, gpio_pkg::PORT_F_DIR_OFS};
    localparam gpio_pkg::addr_t OPT_OFS [gpio_pkg::NUM_PORTS] = '{
        gpio_pkg::PORT_A_OPT_OFS, gpio_pkg::PORT_B_OPT_OFS, gpio_pkg::PORT_C_OPT_OFS,
        gpio_pkg::PORT_D_OPT_OFS, gpio_pkg::PORT_E_OPT_OFS, gpio_pkg::PORT_F_OPT_OFS};
    localparam gpio_pkg::pin_vec_t VEC_PINS [gpio_pkg::NUM_VECTORS] = '{
        gpio_pkg::VEC0_PINS, gpio_pkg::VEC1_PINS, gpio_pkg::VEC2_PINS, gpio_pkg::VEC3_PINS};

    localparam gpio_pkg::pin_vec_t INT_CAP = gpio_pkg::INT_PULLUP | gpio_pkg::INT_FLOAT;
    localparam gpio_pkg::pin_vec_t PU_CAP  = gpio_pkg::PIN_IMPL & ~gpio_pkg::TRUE_OD & ~gpio_pkg::INT_FLOAT;
    localparam gpio_pkg::pin_vec_t OPT_CAP = gpio_pkg::PIN_IMPL & ~gpio_pkg::TRUE_OD;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    gpio_pkg::port_bits_t   data_latch_reg;
    gpio_pkg::port_bits_t   dir_reg;
    gpio_pkg::port_bits_t   opt_reg;
    logic [7:0]             ext_int_sensitivity_reg;
    logic [3:0]             vec_en_reg;
    logic [3:0]             int_req;
    gpio_pkg::pin_vec_t     pin_meta;
    gpio_pkg::pin_vec_t     pin_sync;
    gpio_pkg::pin_vec_t     pin_prev;
    gpio_pkg::pin_vec_t     data_flat;
    gpio_pkg::pin_vec_t     dir_flat;
    gpio_pkg::pin_vec_t     opt_flat;
    gpio_pkg::pin_vec_t     pin_digital;
    gpio_pkg::pin_vec_t     int_sel;
    gpio_pkg::pin_vec_t     push_pull;
    gpio_pkg::pin_vec_t     open_drain;
    gpio_pkg::pin_vec_t     rise;
    gpio_pkg::pin_vec_t     fall;
    gpio_pkg::pin_drive_t   next_drive;
    logic [7:0]             next_rdata;
    logic [3:0]             hit;
    logic [3:0]             sens_change;

    assign data_flat = data_latch_reg;
    assign dir_flat  = dir_reg;
    assign opt_flat  = opt_reg;

    // ------------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Pins routed to the analog mux read as zero, but pin_prev follows the unmasked pin_sync, so a slow analog level still toggles fall.
    assign pin_digital = pin_sync & ~analog_sel_i;

    // ------------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_latch_reg <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_REG_RESET}}; // RQ15
        end else if (bus_i.wr) begin
            for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
                if (bus_i.addr == DATA_OFS[p]) begin
                    data_latch_reg[p] <= bus_i.wdata; // RQ11
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_reg <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_REG_RESET}}; // RQ15
        end else if (bus_i.wr) begin
            for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
                if (bus_i.addr == DIR_OFS[p]) begin
                    dir_reg[p] <= bus_i.wdata;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opt_reg <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_REG_RESET}}; // RQ15
        end else if (bus_i.wr) begin
            for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
                if (bus_i.addr == OPT_OFS[p]) begin
                    opt_reg[p] <= bus_i.wdata & OPT_CAP[p*8 +: 8]; // RQ3
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_int_sensitivity_reg <= gpio_pkg::SENS_RESET;
        end else if (bus_i.wr && bus_i.addr == gpio_pkg::SENS_OFS) begin
            ext_int_sensitivity_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vec_en_reg <= gpio_pkg::VEC_EN_RESET;
        end else if (bus_i.wr && bus_i.addr == gpio_pkg::VEC_EN_OFS) begin
            vec_en_reg <= bus_i.wdata[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            if (bus_i.addr == DATA_OFS[p]) begin
                next_rdata = (dir_reg[p] & data_latch_reg[p])
                           | (~dir_reg[p] & pin_digital[p*8 +: 8]); // RQ11 RQ12
            end
            if (bus_i.addr == DIR_OFS[p]) begin
                next_rdata = dir_reg[p];
            end
            if (bus_i.addr == OPT_OFS[p]) begin
                next_rdata = opt_reg[p];
            end
        end
        if (bus_i.addr == gpio_pkg::SENS_OFS) begin
            next_rdata = ext_int_sensitivity_reg;
        end
        if (bus_i.addr == gpio_pkg::VEC_EN_OFS) begin
            next_rdata = {4'h0, vec_en_reg};
        end
    end

    // Data stands only in the cycle after the read strobe; otherwise the bus sees zero.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    assign push_pull  = dir_flat & opt_flat & OPT_CAP; // RQ1
    assign open_drain = dir_flat & ~push_pull & gpio_pkg::PIN_IMPL; // RQ3 RQ14

    always_comb begin
        next_drive.level   = data_flat & push_pull; // RQ12
        next_drive.oe_n    = ~(push_pull | (open_drain & ~data_flat)); // RQ10 RQ14
        next_drive.pull_en = ~dir_flat & opt_flat & PU_CAP; // RQ1 RQ2
    end

    // Outputs only move on a register write, so stop mode holds them without extra logic.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drive_o <= '{level: '0, oe_n: '1, pull_en: '0};
        end else begin
            drive_o <= next_drive; // RQ7 RQ10
        end
    end

    // ------------------------------------------------------------------
    // External interrupt detection
    // ------------------------------------------------------------------
    assign int_sel = ~dir_flat & opt_flat & INT_CAP; // RQ2 RQ9
    assign rise    = pin_digital & ~pin_prev;
    assign fall    = ~pin_digital & pin_prev;

    always_comb begin
        hit         = 4'h0;
        sens_change = 4'h0;
        for (int v = 0; v < gpio_pkg::NUM_VECTORS; v++) begin
            unique case (gpio_pkg::sens_t'(ext_int_sensitivity_reg[2*v +: 2]))
                gpio_pkg::SENS_FALL_LOW: hit[v] = |(~pin_digital & int_sel & VEC_PINS[v]); // RQ13
                gpio_pkg::SENS_RISE:     hit[v] = |(rise & int_sel & VEC_PINS[v]);
                gpio_pkg::SENS_FALL:     hit[v] = |(fall & int_sel & VEC_PINS[v]);
                gpio_pkg::SENS_BOTH:     hit[v] = |((rise | fall) & int_sel & VEC_PINS[v]);
            endcase
            sens_change[v] = bus_i.wr && bus_i.addr == gpio_pkg::SENS_OFS
                          && bus_i.wdata[2*v +: 2] != ext_int_sensitivity_reg[2*v +: 2];
        end
    end

    // The request latch is invisible to software; a new hit outweighs a fetch in the same cycle.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_req <= 4'h0;
        end else begin
            int_req <= hit | (int_req & ~vec_fetch_i & ~sens_change); // RQ13 RQ9
        end
    end

    assign irq_vec_o = int_req & vec_en_reg & {4{~int_mask_i}}; // RQ8
    assign irq_o     = |irq_vec_o;
    assign wake_o    = |(int_req & vec_en_reg); // RQ6 RQ7

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_push_pull_drive: assert property ( // RQ1
        ##1 $past(dir_flat[16] && opt_flat[16]) |->
            drive_o.oe_n[16] == 1'b0 && drive_o.level[16] == $past(data_flat[16]))
        else $error("push-pull pin not driving its latch");

    a_open_drain_level: assert property ( // RQ14
        ##1 $past(dir_flat[17] && !opt_flat[17]) |->
            drive_o.oe_n[17] == $past(data_flat[17]) && drive_o.level[17] == 1'b0)
        else $error("open-drain pin drive wrong");

    a_true_od_option: assert property ( // RQ3
        opt_reg[0][7:6] == 2'h0 && drive_o.pull_en[7:6] == 2'h0)
        else $error("true open-drain pin has option state");

    a_input_released: assert property ( // RQ11
        ##1 $past(!dir_flat[3]) |-> drive_o.oe_n[3] && !drive_o.level[3])
        else $error("input pin is driven");

    a_read_latch_output: assert property ( // RQ12
        bus_i.rd && bus_i.addr == gpio_pkg::PORT_C_DATA_OFS && dir_reg[2] == 8'hFF
            |=> rdata_o == $past(data_latch_reg[2]))
        else $error("output port read does not return latch");

    a_read_pin_input: assert property ( // RQ11
        bus_i.rd && bus_i.addr == gpio_pkg::PORT_C_DATA_OFS && dir_reg[2] == 8'h00
            |=> rdata_o == $past(pin_digital[23:16]))
        else $error("input port read does not return pin");

    a_irq_needs_unmask: assert property ( // RQ8
        irq_o |-> !int_mask_i && |(int_req & vec_en_reg))
        else $error("interrupt raised while globally masked");

    a_req_needs_select: assert property ( // RQ8
        !int_req[3] && int_sel[12:8] == 5'h00 |=> !int_req[3])
        else $error("request set without interrupt input selected");

    a_fetch_clears: assert property ( // RQ13
        int_req[0] && vec_fetch_i[0] && !hit[0] |=> !int_req[0])
        else $error("vector fetch did not clear request");

    a_req_sticky: assert property ( // RQ13
        int_req[3] && !vec_fetch_i[3] && !sens_change[3] |=> int_req[3] [*1])
        else $error("request dropped without fetch");

    a_wake_on_request: assert property ( // RQ6
        int_req[0] && vec_en_reg[0] |-> wake_o)
        else $error("pending request without wake");

    a_pullup_only_input: assert property ( // RQ2
        drive_o.pull_en[8] |-> $past(!dir_flat[8] && opt_flat[8]))
        else $error("pull-up on a pin not in pull-up input");

    a_unmapped_zero: assert property ( // RQ15
        bus_i.rd && bus_i.addr > gpio_pkg::VEC_EN_OFS |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    c_irq_raised: cover property (##1 $rose(irq_o));
    c_fetch_with_hit: cover property (int_req[3] && vec_fetch_i[3] && hit[3]);
    c_open_drain_release: cover property (open_drain[16] && data_flat[16] ##1 drive_o.oe_n[16]);
    c_sens_clear: cover property (int_req[1] && sens_change[1] ##1 !int_req[1]);

endmodule : gpio_port_block

// *** gpio_pkg.sv ***
package gpio_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_PORTS   = 6;
    localparam int PORT_WIDTH  = 8;
    localparam int NUM_PINS    = NUM_PORTS * PORT_WIDTH;
    localparam int NUM_VECTORS = 4;
    localparam int ADDR_WIDTH  = 5;

    typedef logic [NUM_PINS-1:0]                  pin_vec_t;
    typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] port_bits_t;
    typedef logic [ADDR_WIDTH-1:0]                addr_t;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam addr_t PORT_A_DATA_OFS = 5'h00;
    localparam addr_t PORT_A_DIR_OFS  = 5'h01;
    localparam addr_t PORT_A_OPT_OFS  = 5'h02;
    localparam addr_t PORT_B_DATA_OFS = 5'h03;
    localparam addr_t PORT_B_DIR_OFS  = 5'h04;
    localparam addr_t PORT_B_OPT_OFS  = 5'h05;
    localparam addr_t PORT_C_DATA_OFS = 5'h06;
    localparam addr_t PORT_C_DIR_OFS  = 5'h07;
    localparam addr_t PORT_C_OPT_OFS  = 5'h08;
    localparam addr_t PORT_D_DATA_OFS = 5'h09;
    localparam addr_t PORT_D_DIR_OFS  = 5'h0A;
    localparam addr_t PORT_D_OPT_OFS  = 5'h0B;
    localparam addr_t PORT_E_DATA_OFS = 5'h0C;
    localparam addr_t PORT_E_DIR_OFS  = 5'h0D;
    localparam addr_t PORT_E_OPT_OFS  = 5'h0E;
    localparam addr_t PORT_F_DATA_OFS = 5'h0F;
    localparam addr_t PORT_F_DIR_OFS  = 5'h10;
    localparam addr_t PORT_F_OPT_OFS  = 5'h11;
    localparam addr_t SENS_OFS        = 5'h12;
    localparam addr_t VEC_EN_OFS      = 5'h13;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_REG_RESET = 8'h00;
    localparam logic [7:0] SENS_RESET     = 8'h00;
    localparam logic [3:0] VEC_EN_RESET   = 4'hF;

    // ------------------------------------------------------------------
    // Fixed per-pin features, port F in the top byte
    // ------------------------------------------------------------------
    localparam pin_vec_t PIN_IMPL    = 48'hD7033FFF1FF8;
    localparam pin_vec_t TRUE_OD     = 48'h0000000000C0;
    localparam pin_vec_t INT_PULLUP  = 48'h030000001700;
    localparam pin_vec_t INT_FLOAT   = 48'h040000000808;
    localparam pin_vec_t VEC0_PINS   = 48'h000000000008;
    localparam pin_vec_t VEC1_PINS   = 48'h070000000000;
    localparam pin_vec_t VEC2_PINS   = 48'h000000000800;
    localparam pin_vec_t VEC3_PINS   = 48'h000000001700;

    // ------------------------------------------------------------------
    // Sensitivity codes and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SENS_FALL_LOW = 2'h0,
        SENS_RISE     = 2'h1,
        SENS_FALL     = 2'h2,
        SENS_BOTH     = 2'h3
    } sens_t;

    typedef struct packed {
        addr_t      addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        pin_vec_t level;
        pin_vec_t oe_n;
        pin_vec_t pull_en;
    } pin_drive_t;

endpackage : gpio_pkg

// *** gpio_board_model.sv ***
// --------------------------
// Board side of the port pins
// --------------------------
module gpio_board_model (
    input  wire logic                 clk_i,
    input  wire gpio_pkg::pin_drive_t drive_i,
    input  wire gpio_pkg::pin_vec_t   ext_val_i,
    input  wire gpio_pkg::pin_vec_t   ext_en_i,
    output gpio_pkg::pin_vec_t        pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // A line nobody drives wanders, so it flips every cycle instead of settling.
    gpio_pkg::pin_vec_t float_q = 48'h555555555555;

    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    // Two drivers on one line give an unknown so that a clash cannot pass unseen.
    always_comb begin
        for (int p = 0; p < gpio_pkg::NUM_PINS; p++) begin
            if (!drive_i.oe_n[p] && ext_en_i[p])
                pin_o[p] = 1'bx;
            else if (!drive_i.oe_n[p])
                pin_o[p] = drive_i.level[p];
            else if (ext_en_i[p])
                pin_o[p] = ext_val_i[p];
            else if (drive_i.pull_en[p])
                pin_o[p] = 1'b1;
            else
                pin_o[p] = float_q[p];
        end
    end
endmodule : gpio_board_model

// *** tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------
    // Signals
    // --------------------------
    localparam logic [1:0] WR = 2'h1;
    localparam logic [1:0] RD = 2'h2;
    logic                 clk_i        = 1'b0;
    logic                 arst_n_i     = 1'b0;
    gpio_pkg::bus_req_t   bus_i        = '0;
    logic [7:0]           rdata_o;
    gpio_pkg::pin_vec_t   pin_i;
    gpio_pkg::pin_vec_t   analog_sel_i = '0;
    gpio_pkg::pin_drive_t drive_o;
    logic                 int_mask_i   = 1'b1;
    logic [3:0]           vec_fetch_i  = 4'h0;
    logic [3:0]           irq_vec_o;
    logic                 irq_o;
    logic                 wake_o;
    gpio_pkg::pin_vec_t   ext_val      = '1;
    gpio_pkg::pin_vec_t   ext_en       = 48'h00000000FF3F;
    logic [7:0]           exp_q[$];
    logic                 rd_q         = 1'b0;
    int                   errors          = 0;
    int                   samples_checked = 0;
    int                   cycles          = 0;
    int                   seed            = 73694;
    logic [7:0]           d;
    logic [7:0]           a;
    logic [7:0]           x;
    logic [7:0]           e;

    gpio_port_block dut (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .bus_i       (bus_i),
        .rdata_o     (rdata_o),
        .pin_i       (pin_i),
        .analog_sel_i(analog_sel_i),
        .drive_o     (drive_o),
        .int_mask_i  (int_mask_i),
        .vec_fetch_i (vec_fetch_i),
        .irq_vec_o   (irq_vec_o),
        .irq_o       (irq_o),
        .wake_o      (wake_o)
    );

    gpio_board_model board (
        .clk_i    (clk_i),
        .drive_i  (drive_o),
        .ext_val_i(ext_val),
        .ext_en_i (ext_en),
        .pin_o    (pin_i)
    );

    always #25 clk_i = ~clk_i;

    // --------------------------
    // Tasks
    // --------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Strobes are not lowered at the end, so back-to-back calls never assign twice at one edge.
    task automatic bus(input logic [1:0] op, input gpio_pkg::addr_t ad, input logic [7:0] v);
        @(posedge clk_i);
        bus_i <= '{addr: ad, wdata: v, wr: op == WR, rd: op == RD};
        if (op == RD)
            exp_q.push_back(v);
    endtask : bus

    task automatic settle(input int n);
        bus(2'h0, 5'h00, 8'h00);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wait_out(input logic [5:0] want);
        for (int i = 0; i < 12 && {irq_vec_o, irq_o, wake_o} !== want; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(48'({irq_vec_o, irq_o, wake_o}), 48'(want));
    endtask : wait_out

    task automatic fetch(input logic [3:0] v);
        @(posedge clk_i);
        vec_fetch_i <= v;
        @(posedge clk_i);
        vec_fetch_i <= 4'h0;
    endtask : fetch

    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // --------------------------
    // Watchers
    // --------------------------
    always @(posedge clk_i) begin
        if (rd_q)
            chk(48'(rdata_o), 48'(exp_q.pop_front()));
        rd_q <= bus_i.rd;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // --------------------------
    // Scenarios
    // --------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1;
        chk(drive_o.oe_n, '1);
        chk(drive_o.pull_en, '0);
        for (int p = 0; p < 6; p++) begin
            bus(RD, 5'(p * 3 + 1), 8'h00);
            bus(RD, 5'(p * 3 + 2), 8'h00);
        end
        bus(RD, gpio_pkg::SENS_OFS, gpio_pkg::SENS_RESET);
        bus(RD, gpio_pkg::VEC_EN_OFS, {4'h0, gpio_pkg::VEC_EN_RESET});
        bus(WR, 5'h14, 8'hFF);
        bus(RD, 5'h14, 8'h00);
        bus(RD, 5'h1F, 8'h00);
        repeat (4) begin
            d = 8'($random(seed));
            bus(WR, gpio_pkg::PORT_C_DIR_OFS, d);
            bus(RD, gpio_pkg::PORT_C_DIR_OFS, d);
            bus(WR, gpio_pkg::PORT_C_OPT_OFS, ~d);
            bus(RD, gpio_pkg::PORT_C_OPT_OFS, ~d);
            bus(WR, gpio_pkg::PORT_A_OPT_OFS, d);
            bus(RD, gpio_pkg::PORT_A_OPT_OFS, d & 8'h38);
        end
        // The board lets go of port C before any output mode so no line is fought over.
        for (int m = 0; m < 4; m++) begin
            d = 8'($random(seed));
            x = 8'($random(seed));
            a = (m == 0) ? 8'($random(seed)) : 8'h00;
            e = m[1] ? (m[0] ? 8'h00 : d) : 8'hFF;
            ext_en[23:16] <= 8'h00;
            bus(WR, gpio_pkg::PORT_C_DATA_OFS, d);
            bus(WR, gpio_pkg::PORT_C_DIR_OFS, {8{m[1]}});
            bus(WR, gpio_pkg::PORT_C_OPT_OFS, {8{m[0]}});
            settle(3);
            ext_en[23:16] <= {8{~m[1]}};
            ext_val[23:16] <= x;
            analog_sel_i[23:16] <= a;
            settle(4);
            chk(48'(drive_o.oe_n[23:16]), 48'(e));
            chk(48'(drive_o.pull_en[23:16]), (m == 1) ? 48'hFF : 48'h00);
            chk(48'(drive_o.level[23:16] & ~drive_o.oe_n[23:16]), 48'(d & ~e));
            bus(RD, gpio_pkg::PORT_C_DATA_OFS, m[1] ? d : x & ~a);
            settle(0);
            analog_sel_i <= '0;
        end
        bus(WR, gpio_pkg::PORT_A_DATA_OFS, 8'h40);
        bus(WR, gpio_pkg::PORT_A_DIR_OFS, 8'hC0);
        bus(WR, gpio_pkg::PORT_A_OPT_OFS, 8'hFF);
        settle(3);
        chk(48'({drive_o.oe_n[7:4], drive_o.level[7]}), 48'h0E);
        chk(48'(drive_o.pull_en[7:4]), 48'h3);
        bus(WR, gpio_pkg::PORT_A_DIR_OFS, 8'h00);
        settle(3);
        chk(48'(drive_o.pull_en[7:3]), 48'h06);
        bus(WR, gpio_pkg::SENS_OFS, 8'hA3);
        bus(RD, gpio_pkg::SENS_OFS, 8'hA3);
        settle(2);
        fetch(4'hF);
        // The pin is parked high before its interrupt is enabled, which avoids a spurious event.
        bus(WR, gpio_pkg::PORT_B_OPT_OFS, 8'h01);
        settle(3);
        chk(48'(drive_o.pull_en[15:8]), 48'h01);
        ext_val[9] <= 1'b0;
        settle(6);
        wait_out(6'h00);
        ext_val[8] <= 1'b0;
        wait_out(6'h01);
        int_mask_i <= 1'b0;
        wait_out(6'h23);
        fetch(4'h8);
        wait_out(6'h00);
        for (int i = 0; i < 2; i++) begin
            ext_val[3] <= i[0];
            wait_out(6'h07);
            fetch(4'h1);
            wait_out(6'h00);
        end
        settle(4);
        test_done();
    end
endmodule : tb
